// ### bench/ssalu_freg_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// file register bank seen by the alu
// ---------------------------------------------------------------
module ssalu_freg_model
   import ssalu_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic [6:0] file_raddr,
   output      logic [7:0] file_rdata,
   input  wire ssalu_fwr_s file_wr
);
   logic [7:0] mem [0:127];

   // clear bank, bench preloads operands
   initial
   begin
      foreach (mem[i])
         mem[i] = 8'h00;
   end

   // read port is asynchronous, like the core's bank
   assign file_rdata = mem[file_raddr];

   // write back on the single-cycle strobe
   always @(posedge sys_clk)
   begin
      if (file_wr.we)
         mem[file_wr.addr] <= file_wr.data;
   end
endmodule

// ### bench/subtract_swap_alu_tb.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// bench for subtract and nibble exchange
// ---------------------------------------------------------------
module subtract_swap_alu_tb
   import ssalu_pkg::*;
;
   logic         sys_clk;
   logic         arst_n;
   logic [3:0]   reg_addr;
   logic [7:0]   reg_wdata;
   logic         reg_wr;
   logic         reg_rd;
   logic [7:0]   reg_rdata;
   logic [6:0]   file_raddr;
   logic [7:0]   file_rdata;
   ssalu_fwr_s   file_wr;
   logic [7:0]   acc_out;
   ssalu_flags_s flags_out;
   int           fails;
   int           total_checks;
   int           test_no;
   int unsigned  rnd;

   ssalu_core u_dut (.sys_clk(sys_clk), .arst_n(arst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .file_raddr(file_raddr),
      .file_rdata(file_rdata), .file_wr(file_wr), .acc_out(acc_out),
      .flags_out(flags_out));

   ssalu_freg_model u_fr (.sys_clk(sys_clk), .file_raddr(file_raddr),
      .file_rdata(file_rdata), .file_wr(file_wr));

   // 40 mhz clock
   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // one-cycle write strobe
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask

   // one-cycle read strobe, data checked in the following cycle
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      #1 chk({3'h0, reg_rdata}, {3'h0, exp});
   endtask

   // result and flags {res, c, dc, z}; dc means no borrow from bit 3
   function automatic logic [10:0] expect_fn(input logic [1:0] op,
      input logic [7:0] a, input logic [7:0] b, input logic [2:0] fl);
      logic [7:0] r;
      r = a - b;
      // exchange and idle code both swap nibbles and keep flags
      if (op[1])
         return {a[3:0], a[7:4], fl};
      return {r, a >= b, a[3:0] >= b[3:0], r == 8'h00};
   endfunction

   // full operation: load, start, refused write, timed result checks
   task automatic run_op(input logic [1:0] op, input logic d,
      input logic [7:0] lit, input logic [7:0] acc, input logic [7:0] fv,
      input logic [6:0] fa, input logic [2:0] fl);
      logic [10:0] e;
      logic        to_file;
      u_fr.mem[fa] = fv;
      e = expect_fn(op, (op == 2'h0) ? lit : fv, acc, fl);
      to_file = d && (op != 2'h0);
      wr(OFF_LIT, lit);
      wr(OFF_FADDR, {1'b0, fa});
      wr(OFF_ACC, acc);
      wr(OFF_STATUS, {5'h00, fl[0], fl[1], fl[2]});
      wr(OFF_CMD, {5'h01, d, op});
      wr(OFF_ACC, ~acc);
      @(posedge sys_clk);
      #1 chk({acc_out, flags_out}, {acc, fl});
      @(posedge sys_clk);
      #1 chk({acc_out, flags_out}, {to_file ? acc : e[10:3], e[2:0]});
      rd(OFF_ACC, to_file ? acc : e[10:3]);
      rd(OFF_STATUS, {5'h00, e[0], e[1], e[2]});
      chk({3'h0, u_fr.mem[fa]}, {3'h0, to_file ? e[10:3] : fv});
      test_no++;
      $display("test %0d op %0d done", test_no, op);
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      arst_n    = 1'b0;
      reg_addr  = 4'h0;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      rnd       = $urandom(32'h5276ae95);
      repeat (10) @(posedge sys_clk);
      arst_n <= 1'b1;
      #1 chk({acc_out, flags_out}, {ACC_RST, 3'h0});
      rd(OFF_LIT, LIT_RST);
      run_op(2'h0, 1'b0, 8'h02, 8'h01, 8'h33, 7'h00, 3'h0);
      run_op(2'h0, 1'b1, 8'h02, 8'h02, 8'h33, 7'h00, 3'h0);
      run_op(2'h0, 1'b0, 8'h02, 8'h03, 8'h33, 7'h00, 3'h7);
      run_op(2'h1, 1'b1, 8'h00, 8'h02, 8'h03, 7'h7f, 3'h0);
      run_op(2'h1, 1'b1, 8'h00, 8'h02, 8'h02, 7'h7f, 3'h0);
      run_op(2'h1, 1'b1, 8'h00, 8'h02, 8'h01, 7'h7f, 3'h7);
      run_op(2'h1, 1'b0, 8'h00, 8'h01, 8'h10, 7'h15, 3'h0);
      run_op(2'h2, 1'b0, 8'h00, 8'h11, 8'ha5, 7'h40, 3'h5);
      run_op(2'h2, 1'b1, 8'h00, 8'h11, 8'h3c, 7'h41, 3'h2);
      run_op(2'h3, 1'b0, 8'h00, 8'h11, 8'h96, 7'h42, 3'h6);
      repeat (40)
         run_op(2'($urandom_range(3, 0)), 1'($urandom), 8'($urandom),
            8'($urandom), 8'($urandom), 7'($urandom), 3'($urandom));
      tally_and_finish();
   end

   // run length guard
   initial
   begin
      repeat (100000) @(posedge sys_clk);
      fails++;
      tally_and_finish();
   end
endmodule

// ### rtl/ssalu_core.sv
`timescale 1ns/1ps
// Operation
// RQ1 - literal subtract: decode Q1, fetch literal Q2, compute Q3, write Q4
// RQ2 - positive difference sets carry and clears zero
// RQ3 - negative difference clears carry, stores wrapped eight-bit value
// RQ4 - zero difference sets both carry and zero
// RQ5 - nibble exchange swaps high and low nibbles, flags untouched
// RQ6 - destination bit 0 writes the accumulator, file register unchanged
// RQ7 - destination bit 1 writes the file register, accumulator unchanged (literal subtract ignores it and writes the accumulator)
// RQ8 - literal minus accumulator by two's complement, updates c, dc, z
// RQ9 - register minus accumulator, digit carry means no borrow from bit 3
module ssalu_core
   import ssalu_pkg::*;
#(
   parameter int unsigned WIDTH = 8
)
(
   input  wire logic              sys_clk,
   input  wire logic              arst_n,
   input  wire logic [3:0]        reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output      logic [7:0]        reg_rdata,
   output      logic [6:0]        file_raddr,
   input  wire logic [7:0]        file_rdata,
   output      ssalu_fwr_s        file_wr,
   output      logic [7:0]        acc_out,
   output      ssalu_flags_s      flags_out
);

   // ------------------------------------------------------------
   // elaboration check
   // ------------------------------------------------------------
   if (WIDTH != DATA_W)
   begin : g_bad_width
      $error("ssalu_core supports an eight-bit datapath only");
   end

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   ssalu_phase_e phase_q;
   logic         busy_q;
   ssalu_op_e    op_q;
   logic         dest_q;
   logic [7:0]   lit_q;
   logic [6:0]   faddr_q;
   logic [7:0]   acc_q;
   logic [7:0]   opnd_q;
   logic [7:0]   res_q;
   ssalu_flags_s flags_q;
   ssalu_flags_s newf_q;
   logic [7:0]   rdata_q;
   ssalu_fwr_s   fwr_q;

   // ------------------------------------------------------------
   // register decode
   // ------------------------------------------------------------
   wire wr_cmd   = reg_wr && (reg_addr == OFF_CMD);
   wire wr_lit   = reg_wr && (reg_addr == OFF_LIT);
   wire wr_faddr = reg_wr && (reg_addr == OFF_FADDR);
   wire wr_acc   = reg_wr && (reg_addr == OFF_ACC);
   wire wr_stat  = reg_wr && (reg_addr == OFF_STATUS);
   wire go       = wr_cmd && reg_wdata[CMD_GO] && !busy_q;
   wire [1:0] cmd_op = reg_wdata[CMD_OP_LSB +: 2];

   // ------------------------------------------------------------
   // datapath
   // ------------------------------------------------------------
   // subtract as operand plus inverted accumulator plus one
   wire [8:0] diff = {1'b0, opnd_q} + {1'b0, ~acc_q} + 9'h001;
   wire [4:0] ldiff = {1'b0, opnd_q[3:0]} + {1'b0, ~acc_q[3:0]} + 5'h01;
   wire [7:0] swapped = {opnd_q[NIB_LO +: NIB_W], opnd_q[NIB_HI +: NIB_W]};
   wire       is_sub = (op_q == SSALU_OP_LIT_SUB) ||
                       (op_q == SSALU_OP_REG_SUB);
   wire [7:0] result = is_sub ? diff[7:0] : swapped;
   wire       to_file = (op_q != SSALU_OP_LIT_SUB) && dest_q;
   wire       in_q4 = busy_q && (phase_q == SSALU_Q4);

   // status read-back word
   wire [7:0] status_word = {4'h0, busy_q, flags_q.z, flags_q.dc,
                             flags_q.c};
   wire [7:0] rd_mux = (reg_addr == OFF_LIT)    ? lit_q :
                       (reg_addr == OFF_FADDR)  ? {1'b0, faddr_q} :
                       (reg_addr == OFF_ACC)    ? acc_q :
                       (reg_addr == OFF_STATUS) ? status_word : 8'h00;

   // ------------------------------------------------------------
   // quarter phase sequencer
   // ------------------------------------------------------------
   // RQ1 four phases
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         phase_q <= SSALU_Q1;
         busy_q  <= 1'b0;
         op_q    <= SSALU_OP_NONE;
         dest_q  <= 1'b0;
      end
      else if (go)
      begin
         phase_q <= SSALU_Q1;
         busy_q  <= 1'b1;
         op_q    <= ssalu_op_e'(cmd_op);
         dest_q  <= reg_wdata[CMD_DEST];
      end
      else if (busy_q)
      begin
         case (phase_q)
            SSALU_Q1: phase_q <= SSALU_Q2;
            SSALU_Q2: phase_q <= SSALU_Q3;
            SSALU_Q3: phase_q <= SSALU_Q4;
            SSALU_Q4:
            begin
               phase_q <= SSALU_Q1;
               busy_q  <= 1'b0;
            end
            default: phase_q <= SSALU_Q1;
         endcase
      end
   end

   // ------------------------------------------------------------
   // operand fetch (q2) and compute (q3)
   // ------------------------------------------------------------
   // RQ1 fetch then compute
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         opnd_q <= 8'h00;
         res_q  <= 8'h00;
         newf_q <= '0;
      end
      else if (busy_q && phase_q == SSALU_Q2)
      begin
         opnd_q <= (op_q == SSALU_OP_LIT_SUB) ? lit_q : file_rdata;
      end
      else if (busy_q && phase_q == SSALU_Q3)
      begin
         res_q <= result;
         // RQ2 RQ3 RQ4 carry is no borrow
         newf_q.c  <= diff[8];
         // RQ9 no borrow from bit 3
         newf_q.dc <= ldiff[4];
         newf_q.z  <= (diff[7:0] == 8'h00);
      end
   end

   // ------------------------------------------------------------
   // software registers and q4 write-back
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         lit_q   <= LIT_RST;
         faddr_q <= 7'h00;
         acc_q   <= ACC_RST;
         flags_q <= '0;
         fwr_q   <= '0;
         rdata_q <= 8'h00;
      end
      else
      begin
         rdata_q <= reg_rd ? rd_mux : 8'h00;
         fwr_q   <= '0;
         if (wr_lit && !busy_q)
            lit_q <= reg_wdata;
         if (wr_faddr && !busy_q)
            faddr_q <= reg_wdata[6:0];
         if (in_q4)
         begin
            // RQ6 RQ7 destination select
            if (to_file)
               fwr_q <= '{addr: faddr_q, data: res_q, we: 1'b1};
            else
               acc_q <= res_q;
            // RQ5 RQ8 flags only for subtracts
            if (is_sub)
               flags_q <= newf_q;
         end
         else
         begin
            if (wr_acc && !busy_q)
               acc_q <= reg_wdata;
            if (wr_stat && !busy_q)
               flags_q <= '{c: reg_wdata[ST_C], dc: reg_wdata[ST_DC],
                            z: reg_wdata[ST_Z]};
         end
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign reg_rdata  = rdata_q;
   assign file_raddr = faddr_q;
   assign file_wr    = fwr_q;
   assign acc_out    = acc_q;
   assign flags_out  = flags_q;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   // RQ1 phase order
   property p_phase_walk;
      @(posedge sys_clk) disable iff (!arst_n)
      go |=> busy_q && phase_q == SSALU_Q1 ##1 phase_q == SSALU_Q2
         ##1 phase_q == SSALU_Q3 ##1 phase_q == SSALU_Q4 ##1 !busy_q;
   endproperty
   a_phase_walk: assert property (p_phase_walk) // RQ1
      else $error("quarter phase walk broken");

   // RQ2 positive flags
   property p_pos_flags;
      @(posedge sys_clk) disable iff (!arst_n)
      in_q4 && is_sub && newf_q.c && !newf_q.z |=> flags_q.c && !flags_q.z;
   endproperty
   a_pos_flags: assert property (p_pos_flags) // RQ2
      else $error("positive result flags wrong");

   // RQ3 wrapped negative
   property p_neg;
      @(posedge sys_clk) disable iff (!arst_n)
      busy_q && phase_q == SSALU_Q3 && is_sub && opnd_q < acc_q
         |=> !newf_q.c && res_q == 8'(opnd_q - $past(acc_q));
   endproperty
   a_neg: assert property (p_neg) // RQ3
      else $error("negative result not wrapped");

   // RQ4 zero flags
   property p_zero;
      @(posedge sys_clk) disable iff (!arst_n)
      busy_q && phase_q == SSALU_Q3 && is_sub && opnd_q == acc_q
         |=> ##1 flags_q.c && flags_q.z;
   endproperty
   a_zero: assert property (p_zero) // RQ4
      else $error("zero result flags wrong");

   // RQ5 nibbles exchanged, flags kept
   property p_swap;
      @(posedge sys_clk) disable iff (!arst_n)
      in_q4 && op_q == SSALU_OP_SWAP |=> $stable(flags_q)
         && (fwr_q.we ? fwr_q.data : acc_q) ==
            {$past(opnd_q[3:0]), $past(opnd_q[7:4])};
   endproperty
   a_swap: assert property (p_swap) // RQ5
      else $error("nibble exchange wrong");

   // RQ6 accumulator destination
   property p_dest_acc;
      @(posedge sys_clk) disable iff (!arst_n)
      in_q4 && !to_file |=> !fwr_q.we && acc_q == $past(res_q);
   endproperty
   a_dest_acc: assert property (p_dest_acc) // RQ6
      else $error("accumulator destination wrong");

   // RQ7 file destination
   property p_dest_file;
      @(posedge sys_clk) disable iff (!arst_n)
      in_q4 && to_file |=> fwr_q.we && $stable(acc_q)
         && fwr_q.addr == faddr_q;
   endproperty
   a_dest_file: assert property (p_dest_file) // RQ7
      else $error("file destination wrong");

   // RQ7 file data, one pulse
   property p_file_data;
      @(posedge sys_clk) disable iff (!arst_n)
      in_q4 && to_file |=> fwr_q.data == $past(res_q) ##1 !fwr_q.we;
   endproperty
   a_file_data: assert property (p_file_data) // RQ7
      else $error("file write data or pulse wrong");

   // RQ8 literal operand source
   property p_lit_src;
      @(posedge sys_clk) disable iff (!arst_n)
      busy_q && phase_q == SSALU_Q2 && op_q == SSALU_OP_LIT_SUB
         |=> opnd_q == lit_q ##2 !fwr_q.we;
   endproperty
   a_lit_src: assert property (p_lit_src) // RQ8
      else $error("literal subtract source wrong");

   // RQ8 operands held while busy
   property p_hold;
      @(posedge sys_clk) disable iff (!arst_n)
      busy_q && phase_q != SSALU_Q4 |=> $stable(acc_q) && $stable(lit_q);
   endproperty
   a_hold: assert property (p_hold) // RQ8
      else $error("operand changed while busy");

   // RQ9 digit carry
   property p_dc;
      @(posedge sys_clk) disable iff (!arst_n)
      busy_q && phase_q == SSALU_Q3 && is_sub
         |=> newf_q.dc == ($past(opnd_q[3:0]) >= $past(acc_q[3:0]));
   endproperty
   a_dc: assert property (p_dc) // RQ9
      else $error("digit carry wrong");

endmodule

// ### rtl/ssalu_pkg.sv
package ssalu_pkg;

   // ------------------------------------------------------------
   // widths and field layout
   // ------------------------------------------------------------
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 7;
   localparam int unsigned NIB_LO = 0;
   localparam int unsigned NIB_HI = 4;
   localparam int unsigned NIB_W  = 4;

   // ------------------------------------------------------------
   // register port offsets
   // ------------------------------------------------------------
   localparam logic [3:0] OFF_CMD    = 4'h0; // w: op, dest, start
   localparam logic [3:0] OFF_LIT    = 4'h1; // rw: literal operand
   localparam logic [3:0] OFF_FADDR  = 4'h2; // rw: file register address
   localparam logic [3:0] OFF_ACC    = 4'h3; // rw: accumulator
   localparam logic [3:0] OFF_STATUS = 4'h4; // rw: c, dc, z, busy

   // command register bit positions
   localparam int unsigned CMD_OP_LSB = 0; // 2 bits
   localparam int unsigned CMD_DEST   = 2;
   localparam int unsigned CMD_GO     = 3;
   // status register bit positions
   localparam int unsigned ST_C    = 0;
   localparam int unsigned ST_DC   = 1;
   localparam int unsigned ST_Z    = 2;
   localparam int unsigned ST_BUSY = 3;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [7:0] LIT_RST = 8'h00;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0]
   {
      SSALU_OP_LIT_SUB = 2'h0, // literal_minus_acc
      SSALU_OP_REG_SUB = 2'h1, // reg_minus_acc
      SSALU_OP_SWAP    = 2'h2, // nibble_exchange
      SSALU_OP_NONE    = 2'h3
   } ssalu_op_e;

   typedef enum logic [1:0] {SSALU_Q1, SSALU_Q2, SSALU_Q3, SSALU_Q4}
      ssalu_phase_e;

   typedef struct packed
   {
      logic c;
      logic dc;
      logic z;
   } ssalu_flags_s;

   typedef struct packed
   {
      logic [6:0] addr;
      logic [7:0] data;
      logic       we;
   } ssalu_fwr_s;

endpackage
